// ==== rtl/dfs_defs.svh ====
// constants for the drive fault supervisor: offsets, field positions, resets, timing
`ifndef DFS_DEFS_SVH
`define DFS_DEFS_SVH

// wishbone word offsets (byte addresses)
`define DFS_OFF_CTRL        8'h00
`define DFS_OFF_FAULT       8'h04
`define DFS_OFF_WARN        8'h08
`define DFS_OFF_STATUS      8'h0C
`define DFS_OFF_VEL_THR     8'h10
`define DFS_OFF_POS_THR     8'h14
`define DFS_OFF_REGEN_PWR   8'h18
`define DFS_OFF_MOTOR_TEMP  8'h1C
`define DFS_OFF_CAN_TMO     8'h20
`define DFS_OFF_DECEL       8'h24

// control register fields
`define DFS_CTRL_ENABLE     0
`define DFS_CTRL_LIMIT_EN   1
`define DFS_CTRL_PROFILE    2
`define DFS_CTRL_STEP_REF   3
`define DFS_CTRL_MODE_LO    4
`define DFS_CTRL_MODE_HI    5

// fault register bit positions
`define DFS_F_RESOLVER      0
`define DFS_F_ANALOG        1
`define DFS_F_MAINS         2
`define DFS_F_CANLOSS       3
`define DFS_F_PROGERR       4
`define DFS_F_QSTOP         5
`define DFS_F_INLOSS        6
`define DFS_F_REGEN_FUSE    7
`define DFS_F_PSU_TEMP      8
`define DFS_F_AMP_TEMP      9
`define DFS_F_MOTOR_TEMP    10
`define DFS_NUM_FAULTS      11

// warning register bit positions
`define DFS_W_FOLDBACK      0
`define DFS_W_MOTOR_TH      1
`define DFS_W_AMP_TH        2
`define DFS_W_POS_TRACK     3
`define DFS_W_VEL_TRACK     4
`define DFS_W_REGEN_LIM     5
`define DFS_W_LIMIT         6
`define DFS_NUM_WARNS       7

// display codes: high nibble letter (F=0xF, U=0xA), low nibble number
`define DFS_CODE_NONE       8'h00
`define DFS_CODE_F3         8'hF3
`define DFS_CODE_F4         8'hF4
`define DFS_CODE_F5         8'hF5
`define DFS_CODE_F6         8'hF6
`define DFS_CODE_F8         8'hF8
`define DFS_CODE_F9         8'hF9
`define DFS_CODE_U1         8'hA1
`define DFS_CODE_U2         8'hA2
`define DFS_CODE_U3         8'hA3
`define DFS_CODE_U4         8'hA4
`define DFS_CODE_U5         8'hA5
`define DFS_CODE_U6         8'hA6
`define DFS_CODE_U7         8'hA7
`define DFS_CODE_U8         8'hA8
`define DFS_CODE_U9         8'hA9
`define DFS_CODE_UA         8'hAA
`define DFS_CODE_UB         8'hAB
`define DFS_CODE_FOLD       8'hD0

// temperatures in degrees celsius
`define DFS_MOTOR_FAULT_C   8'd155
`define DFS_MOTOR_WARN_C    8'd130

// reset values
`define DFS_CTRL_RST        8'h02
`define DFS_VEL_THR_RST     16'h0400
`define DFS_POS_THR_RST     16'h0400
`define DFS_CAN_TMO_RST     16'h4E20
`define DFS_DECEL_RST       16'h0FA0

// regen averaging period in ms and cycles at 20 MHz
`define DFS_CLK_HZ          20000000
`define DFS_AVG_PERIOD_MS   100
`define DFS_AVG_CYCLES      ((`DFS_CLK_HZ / 1000) * `DFS_AVG_PERIOD_MS)
// can timeout counter ticks once per ms
`define DFS_MS_CYCLES       (`DFS_CLK_HZ / 1000)

`endif

// ==== rtl/dfs_pkg.sv ====
// types for the drive fault supervisor
package dfs_pkg;
  typedef enum logic [1:0] {
    DFS_RUN   = 2'b00,
    DFS_DECEL = 2'b01,
    DFS_OFF   = 2'b10
  } dfs_state_t;

  typedef enum logic [1:0] {
    DFS_MODE_TORQUE   = 2'b00,
    DFS_MODE_VELOCITY = 2'b01,
    DFS_MODE_POSITION = 2'b10,
    DFS_MODE_INTERP   = 2'b11
  } dfs_mode_t;
endpackage

// ==== rtl/dfs_sync.sv ====
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module dfs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // no reset: pins flush through while reset is held; a zero here reads as a fault
  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    q_o    <= meta_q;
  end
endmodule

// ==== rtl/dfs_regen_avg.sv ====
// regeneration power averager over a fixed period
`timescale 1ns/1ps
`include "dfs_defs.svh"
module dfs_regen_avg (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] power_sample_i,
  output logic      [15:0] avg_power_o
);
  localparam int unsigned CNT_MAX = `DFS_AVG_CYCLES - 1;
  localparam int          SHIFT   = 21;

  logic [21:0] cnt_q;
  logic [37:0] acc_q;
  logic        wrap;

  assign wrap = (cnt_q == CNT_MAX[21:0]);

  always_ff @(posedge clk_i) begin
    if (rst_i || wrap) begin
      cnt_q <= 22'h000000;
    end else begin
      cnt_q <= cnt_q + 22'h000001;
    end
  end

  // shift approximates divide by period; 2^21 vs 2e6 is within the stated accuracy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q       <= 38'h0;
      avg_power_o <= 16'h0000;
    end else if (wrap) begin
      acc_q       <= {22'h000000, power_sample_i};
      avg_power_o <= 16'((acc_q + {22'h000000, power_sample_i}) >> SHIFT);
    end else begin
      acc_q <= acc_q + {22'h000000, power_sample_i};
    end
  end
endmodule

// ==== rtl/dfs_top.sv ====
// drive fault supervisor: fault latching, reactions, warnings and wishbone registers
`timescale 1ns/1ps
`include "dfs_defs.svh"
// Function
// - resolver loss disables at once, latches, shows F8
// - analog supply low disables, latches, shows F9
// - mains or power-ready absent: U1, decelerate, disable
// - during soft start report not-ready, refuse enable
// - can receive/transmit loss raises U7
// - profile mode bad command: U9, decelerate, disable
// - quick-stop input: UA, decelerate, disable
// - reference input loss: Ub, hold position
// - regen fuse blown: decelerate, disable, latch F3
// - fuse blown at power-up reports all supply faults
// - rectifier overheat: decelerate, disable, latch F4
// - inverter overheat: decelerate, disable, latch F5
// - winding above 155C disables, latches, shows F6
// - foldback warning while torque clamped thermally
// - winding above 130C warns without disabling
// - heatsink past warning temperature warns
// - position tracking warning only in position/interp modes
// - velocity tracking warning in position/velocity modes
// - regen resistor overload raises regen-limit warning
// - velocity mode limits block motion that direction
// - limit warning follows inputs, hidden when disabled
// - average regen power readable per period
// - latched fault holds until re-enable
// - non-fatal fault: emergency decel, then disable
// - fatal fault: stop switching immediately
module dfs_top
  import dfs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        resolver_ok_i,
  input  wire logic        analog_ok_i,
  input  wire logic        mains_ok_i,
  input  wire logic        power_ready_i,
  input  wire logic        soft_start_i,
  input  wire logic        can_rx_ok_i,
  input  wire logic        can_tx_ok_i,
  input  wire logic        bad_command_i,
  input  wire logic        quick_stop_i,
  input  wire logic        ref_input_ok_i,
  input  wire logic        regen_fuse_ok_i,
  input  wire logic        psu_hot_i,
  input  wire logic        amp_hot_i,
  input  wire logic        amp_warm_i,
  input  wire logic        foldback_i,
  input  wire logic        regen_overload_i,
  input  wire logic        limit_cw_i,
  input  wire logic        limit_ccw_i,
  input  wire logic [7:0]  motor_temp_i,
  input  wire logic [15:0] pos_error_i,
  input  wire logic [15:0] vel_error_i,
  input  wire logic [15:0] regen_power_i,
  input  wire logic        motion_stopped_i,
  output logic             pwm_enable_o,
  output logic             decel_o,
  output logic [15:0]      decel_rate_o,
  output logic             hold_position_o,
  output logic             block_cw_o,
  output logic             block_ccw_o,
  output logic [7:0]       display_code_o,
  output logic [15:0]      regen_power_query_o,
  output logic [15:0]      regen_average_power_param_o
);
  localparam int NP = 15;

  // pin level inputs through two flops
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] pin_s;
  assign pin_raw = {resolver_ok_i, analog_ok_i, mains_ok_i, power_ready_i, soft_start_i,
                    can_rx_ok_i, can_tx_ok_i, quick_stop_i, ref_input_ok_i,
                    regen_fuse_ok_i, psu_hot_i, amp_hot_i, amp_warm_i,
                    limit_cw_i, limit_ccw_i};

  dfs_sync #(.W(NP)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pin_raw),
    .q_o   (pin_s)
  );

  logic s_res_ok, s_ana_ok, s_mains_ok, s_pwr_rdy, s_soft, s_rx_ok, s_tx_ok, s_qstop;
  logic s_ref_ok, s_fuse_ok, s_psu_hot, s_amp_hot, s_amp_warm, s_lim_cw, s_lim_ccw;
  assign {s_res_ok, s_ana_ok, s_mains_ok, s_pwr_rdy, s_soft, s_rx_ok, s_tx_ok, s_qstop,
          s_ref_ok, s_fuse_ok, s_psu_hot, s_amp_hot, s_amp_warm, s_lim_cw, s_lim_ccw} = pin_s;

  // registers
  logic [7:0]  ctrl_q;
  logic [15:0] vel_thr_q;
  logic [15:0] pos_thr_q;
  logic [15:0] can_tmo_q;
  logic [15:0] decel_q;
  logic [`DFS_NUM_FAULTS-1:0] fault_q;
  logic [`DFS_NUM_WARNS-1:0]  warn_q;
  dfs_state_t  state_q;
  logic        enable_q;
  logic        fuse_at_boot_q;
  logic        boot_done_q;
  logic [15:0] rx_ms_q;
  logic [14:0] ms_div_q;
  logic [15:0] regen_avg;

  dfs_mode_t mode;
  assign mode = dfs_mode_t'(ctrl_q[`DFS_CTRL_MODE_HI:`DFS_CTRL_MODE_LO]);

  logic wb_req;
  logic wb_wr;
  logic enable_rise;
  logic enable_clear;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o; // lands on the ack edge

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q    <= `DFS_CTRL_RST;
      vel_thr_q <= `DFS_VEL_THR_RST;
      pos_thr_q <= `DFS_POS_THR_RST;
      can_tmo_q <= `DFS_CAN_TMO_RST;
      decel_q   <= `DFS_DECEL_RST;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        `DFS_OFF_CTRL: if (wb_sel_i[0]) ctrl_q <= wb_dat_i[7:0];
        `DFS_OFF_VEL_THR: begin
          if (wb_sel_i[0]) vel_thr_q[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) vel_thr_q[15:8] <= wb_dat_i[15:8];
        end
        `DFS_OFF_POS_THR: begin
          if (wb_sel_i[0]) pos_thr_q[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) pos_thr_q[15:8] <= wb_dat_i[15:8];
        end
        `DFS_OFF_CAN_TMO: begin
          if (wb_sel_i[0]) can_tmo_q[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) can_tmo_q[15:8] <= wb_dat_i[15:8];
        end
        `DFS_OFF_DECEL: begin
          if (wb_sel_i[0]) decel_q[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) decel_q[15:8] <= wb_dat_i[15:8];
        end
        default: ;
      endcase
    end
  end

  // fault clearing happens on the rising edge of the enable bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= ctrl_q[`DFS_CTRL_ENABLE];
    end
  end
  assign enable_rise  = ctrl_q[`DFS_CTRL_ENABLE] && !enable_q;
  assign enable_clear = enable_rise;

  // fuse state captured once after reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_done_q    <= 1'b0;
      fuse_at_boot_q <= 1'b0;
    end else if (!boot_done_q) begin
      boot_done_q    <= 1'b1;
      fuse_at_boot_q <= !s_fuse_ok;
    end
  end

  // can receive watchdog in ms
  always_ff @(posedge clk_i) begin
    if (rst_i || ms_div_q == 15'(`DFS_MS_CYCLES - 1)) begin
      ms_div_q <= 15'h0000;
    end else begin
      ms_div_q <= ms_div_q + 15'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || s_rx_ok) begin
      rx_ms_q <= 16'h0000;
    end else if (ms_div_q == 15'h0000 && rx_ms_q != 16'hFFFF) begin
      rx_ms_q <= rx_ms_q + 16'h0001;
    end
  end

  // live fault causes
  logic [`DFS_NUM_FAULTS-1:0] cause;
  logic supply_all;
  assign supply_all = fuse_at_boot_q;
  always_comb begin
    cause = '0;
    cause[`DFS_F_RESOLVER]   = !s_res_ok;
    cause[`DFS_F_ANALOG]     = !s_ana_ok || supply_all;
    cause[`DFS_F_MAINS]      = !s_mains_ok || !s_pwr_rdy || s_soft || supply_all;
    cause[`DFS_F_CANLOSS]    = !s_tx_ok || (rx_ms_q >= can_tmo_q);
    cause[`DFS_F_PROGERR]    = ctrl_q[`DFS_CTRL_PROFILE] && bad_command_i;
    cause[`DFS_F_QSTOP]      = s_qstop;
    cause[`DFS_F_INLOSS]     = ctrl_q[`DFS_CTRL_STEP_REF] && !s_ref_ok;
    cause[`DFS_F_REGEN_FUSE] = !s_fuse_ok || supply_all;
    cause[`DFS_F_PSU_TEMP]   = s_psu_hot || supply_all;
    cause[`DFS_F_AMP_TEMP]   = s_amp_hot;
    cause[`DFS_F_MOTOR_TEMP] = motor_temp_i > `DFS_MOTOR_FAULT_C;
  end

  // latched faults hold; level faults (mains, soft start, quick stop, input loss) follow
  localparam logic [`DFS_NUM_FAULTS-1:0] LATCHING = 11'b111_1001_1011;
  genvar gi;
  generate
    for (gi = 0; gi < `DFS_NUM_FAULTS; gi++) begin : g_fault
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          fault_q[gi] <= 1'b0;
        end else if (cause[gi]) begin
          fault_q[gi] <= 1'b1;
        end else if (!LATCHING[gi] || enable_clear) begin
          fault_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  logic fatal;
  logic nonfatal;
  assign fatal = fault_q[`DFS_F_RESOLVER] || fault_q[`DFS_F_ANALOG] ||
                 fault_q[`DFS_F_MOTOR_TEMP];
  assign nonfatal = fault_q[`DFS_F_MAINS] || fault_q[`DFS_F_CANLOSS] ||
                    fault_q[`DFS_F_PROGERR] || fault_q[`DFS_F_QSTOP] ||
                    fault_q[`DFS_F_REGEN_FUSE] || fault_q[`DFS_F_PSU_TEMP] ||
                    fault_q[`DFS_F_AMP_TEMP];
  logic cause_stop;
  assign cause_stop = |{cause[`DFS_F_MOTOR_TEMP:`DFS_F_REGEN_FUSE],
                        cause[`DFS_F_QSTOP:`DFS_F_RESOLVER]};

  // reaction sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= DFS_OFF;
    end else begin
      unique case (state_q)
        DFS_RUN: begin
          if (!ctrl_q[`DFS_CTRL_ENABLE] || fatal) begin
            state_q <= DFS_OFF;
          end else if (nonfatal) begin
            state_q <= DFS_DECEL;
          end
        end
        DFS_DECEL: begin
          if (fatal || motion_stopped_i || !ctrl_q[`DFS_CTRL_ENABLE]) begin
            state_q <= DFS_OFF;
          end
        end
        DFS_OFF: begin
          // live causes except input loss gate the start, latched bits clear on this edge; soft start is mains
          if (enable_rise && !cause_stop) begin
            state_q <= DFS_RUN;
          end
        end
        default: state_q <= DFS_OFF;
      endcase
    end
  end

  // regen average after the current period
  dfs_regen_avg u_regen (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .power_sample_i (regen_power_i),
    .avg_power_o    (regen_avg)
  );

  // warnings are live levels
  logic [`DFS_NUM_WARNS-1:0] warn_d;
  logic pos_mode;
  logic vel_mode;
  assign pos_mode = (mode == DFS_MODE_POSITION) || (mode == DFS_MODE_INTERP);
  assign vel_mode = (mode == DFS_MODE_VELOCITY);
  always_comb begin
    warn_d = '0;
    warn_d[`DFS_W_FOLDBACK]  = foldback_i;
    warn_d[`DFS_W_MOTOR_TH]  = motor_temp_i > `DFS_MOTOR_WARN_C;
    warn_d[`DFS_W_AMP_TH]    = s_amp_warm;
    warn_d[`DFS_W_POS_TRACK] = pos_mode && (pos_error_i > pos_thr_q);
    warn_d[`DFS_W_VEL_TRACK] = (pos_mode || vel_mode) && (vel_error_i > vel_thr_q);
    warn_d[`DFS_W_REGEN_LIM] = regen_overload_i;
    warn_d[`DFS_W_LIMIT]     = ctrl_q[`DFS_CTRL_LIMIT_EN] && (s_lim_cw || s_lim_ccw);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warn_q <= '0;
    end else begin
      warn_q <= warn_d;
    end
  end

  // outputs registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_enable_o    <= 1'b0;
      decel_o         <= 1'b0;
      decel_rate_o    <= 16'h0000;
      hold_position_o <= 1'b0;
      block_cw_o      <= 1'b0;
      block_ccw_o     <= 1'b0;
    end else begin
      pwm_enable_o    <= (state_q != DFS_OFF) && !fatal;
      decel_o         <= (state_q == DFS_DECEL) && !fatal;
      decel_rate_o    <= decel_q;
      hold_position_o <= fault_q[`DFS_F_INLOSS];
      block_cw_o      <= vel_mode && ctrl_q[`DFS_CTRL_LIMIT_EN] && s_lim_cw;
      block_ccw_o     <= vel_mode && ctrl_q[`DFS_CTRL_LIMIT_EN] && s_lim_ccw;
      regen_power_query_o         <= regen_avg;
      regen_average_power_param_o <= regen_avg;
    end
  end

  // display priority: fatal first, then non-fatal, then warnings
  logic [7:0] code_d;
  always_comb begin
    code_d = `DFS_CODE_NONE;
    if      (fault_q[`DFS_F_RESOLVER])   code_d = `DFS_CODE_F8;
    else if (fault_q[`DFS_F_ANALOG])     code_d = `DFS_CODE_F9;
    else if (fault_q[`DFS_F_MOTOR_TEMP]) code_d = `DFS_CODE_F6;
    else if (fault_q[`DFS_F_REGEN_FUSE]) code_d = `DFS_CODE_F3;
    else if (fault_q[`DFS_F_PSU_TEMP])   code_d = `DFS_CODE_F4;
    else if (fault_q[`DFS_F_AMP_TEMP])   code_d = `DFS_CODE_F5;
    else if (fault_q[`DFS_F_MAINS])      code_d = `DFS_CODE_U1;
    else if (fault_q[`DFS_F_CANLOSS])    code_d = `DFS_CODE_U7;
    else if (fault_q[`DFS_F_PROGERR])    code_d = `DFS_CODE_U9;
    else if (fault_q[`DFS_F_QSTOP])      code_d = `DFS_CODE_UA;
    else if (fault_q[`DFS_F_INLOSS])     code_d = `DFS_CODE_UB;
    else if (warn_q[`DFS_W_MOTOR_TH])    code_d = `DFS_CODE_U2;
    else if (warn_q[`DFS_W_AMP_TH])      code_d = `DFS_CODE_U3;
    else if (warn_q[`DFS_W_POS_TRACK])   code_d = `DFS_CODE_U4;
    else if (warn_q[`DFS_W_VEL_TRACK])   code_d = `DFS_CODE_U5;
    else if (warn_q[`DFS_W_REGEN_LIM])   code_d = `DFS_CODE_U6;
    else if (warn_q[`DFS_W_LIMIT])       code_d = `DFS_CODE_U8;
    else if (warn_q[`DFS_W_FOLDBACK])    code_d = `DFS_CODE_FOLD;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      display_code_o <= `DFS_CODE_NONE;
    end else begin
      display_code_o <= code_d;
    end
  end

  // read mux; unmapped reads zero, writes there ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req) begin
      unique case (wb_adr_i)
        `DFS_OFF_CTRL:       wb_dat_o <= {24'h000000, ctrl_q};
        `DFS_OFF_FAULT:      wb_dat_o <= {21'h000000, fault_q};
        `DFS_OFF_WARN:       wb_dat_o <= {25'h0000000, warn_q};
        `DFS_OFF_STATUS:     wb_dat_o <= {22'h000000, state_q, display_code_o};
        `DFS_OFF_VEL_THR:    wb_dat_o <= {16'h0000, vel_thr_q};
        `DFS_OFF_POS_THR:    wb_dat_o <= {16'h0000, pos_thr_q};
        `DFS_OFF_REGEN_PWR:  wb_dat_o <= {16'h0000, regen_avg};
        `DFS_OFF_MOTOR_TEMP: wb_dat_o <= {24'h000000, motor_temp_i};
        `DFS_OFF_CAN_TMO:    wb_dat_o <= {16'h0000, can_tmo_q};
        `DFS_OFF_DECEL:      wb_dat_o <= {16'h0000, decel_q};
        default:             wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule

// ==== bench/dfs_plant.sv ====
// motion controller stand-in: completes an emergency stop after a set delay
`timescale 1ns/1ps
module dfs_plant (
  input  wire logic       clk_i,
  input  wire logic       decel_i,
  input  wire logic [7:0] delay_i,
  output logic            stopped_o
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk_i) begin
    if (!decel_i) cnt_q <= 8'h00;
    else if (cnt_q != delay_i) cnt_q <= cnt_q + 8'h01;
  end
  // stop reported only once the ramp has run, never early
  assign stopped_o = decel_i && (cnt_q == delay_i);
endmodule

// ==== bench/dfs_top_properties.sv ====
// port checker for the drive fault supervisor
`timescale 1ns/1ps
module dfs_top_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       resolver_ok_i,
  input wire logic       analog_ok_i,
  input wire logic       soft_start_i,
  input wire logic       limit_cw_i,
  input wire logic       motion_stopped_i,
  input wire logic [7:0] motor_temp_i,
  input wire logic       pwm_enable_o,
  input wire logic       decel_o,
  input wire logic       block_cw_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bounds cover sync lag plus state update
  chk_resolver_off: assert property (
    $fell(resolver_ok_i) |-> ##[1:6] !pwm_enable_o) else $error("pwm on after resolver loss");
  chk_analog_off: assert property (
    $fell(analog_ok_i) |-> ##[1:6] !pwm_enable_o) else $error("pwm on after analog loss");
  chk_winding_off: assert property (
    motor_temp_i > 8'd155 |-> ##[1:4] !pwm_enable_o) else $error("pwm on with hot winding");
  chk_limit_quiet: assert property (
    !limit_cw_i [*5] |-> !block_cw_o) else $error("cw blocked without limit");
  chk_decel_hold: assert property (
    decel_o && !motion_stopped_i |=> decel_o or ##[0:2] !pwm_enable_o)
    else $error("decel dropped before stop");
  chk_stop_off: assert property (
    decel_o && motion_stopped_i |-> ##[1:3] !pwm_enable_o) else $error("pwm on after stop");
  chk_soft_refuse: assert property (
    soft_start_i [*5] |-> !$rose(pwm_enable_o)) else $error("enabled in soft start");
  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
endmodule
bind dfs_top dfs_top_checker chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .resolver_ok_i, .analog_ok_i, .soft_start_i, .limit_cw_i, .motion_stopped_i,
  .motor_temp_i, .pwm_enable_o, .decel_o, .block_cw_o);

// ==== bench/tb_dfs_top.sv ====
// self-checking bench for the drive fault supervisor
`timescale 1ns/1ps
`include "dfs_defs.svh"
module tb_dfs_top;
  import dfs_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, we = 1'b0, ack, pwm, dec, stp, hold, bcw, bccw;
  logic [7:0]  adr = 8'h00, disp, temp = 8'd25, dly = 8'h01;
  logic [31:0] wdat = 32'h0, rdat, dato, seed = 32'hAAC5;
  logic [9:0]  flt = 10'h000;
  logic        lcw = 1'b0, ss = 1'b0, refok = 1'b1, fold = 1'b0, ovl = 1'b0, warm = 1'b0;
  logic [15:0] perr = 16'h0, verr = 16'h0, rpow = 16'h0, rate;
  int          n_errors = 0, compares = 0;
  // flt order: psu, amp, fuse, qstop, mains, resolver, cmd, analog, winding, can tx
  localparam logic [7:0] CODE [10] = '{`DFS_CODE_F4, `DFS_CODE_F5, `DFS_CODE_F3,
    `DFS_CODE_UA, `DFS_CODE_U1, `DFS_CODE_F8, `DFS_CODE_U9, `DFS_CODE_F9, `DFS_CODE_F6,
    `DFS_CODE_U7};
  localparam int FBIT [10] = '{8, 9, 7, 5, 2, 0, 4, 1, 10, 3};
  always #25 clk_i = ~clk_i;
  dfs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
    .resolver_ok_i(!flt[5]), .analog_ok_i(!flt[7]), .mains_ok_i(!flt[4]),
    .power_ready_i(1'b1), .soft_start_i(ss), .can_rx_ok_i(1'b1), .can_tx_ok_i(!flt[9]),
    .bad_command_i(flt[6]), .quick_stop_i(flt[3]), .ref_input_ok_i(refok),
    .regen_fuse_ok_i(!flt[2]), .psu_hot_i(flt[0]), .amp_hot_i(flt[1]), .amp_warm_i(warm),
    .foldback_i(fold), .regen_overload_i(ovl), .limit_cw_i(lcw), .limit_ccw_i(lcw),
    .motor_temp_i(flt[8] ? 8'd156 : temp), .pos_error_i(perr), .vel_error_i(verr),
    .regen_power_i(rpow), .motion_stopped_i(stp), .pwm_enable_o(pwm), .decel_o(dec),
    .decel_rate_o(rate), .hold_position_o(hold), .block_cw_o(bcw), .block_ccw_o(bccw),
    .display_code_o(disp), .regen_power_query_o(), .regen_average_power_param_o());
  dfs_plant pl (.clk_i(clk_i), .decel_i(dec), .delay_i(dly), .stopped_o(stp));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] rv(logic [7:0] a);
    case (a)
      `DFS_OFF_CTRL: return 32'(`DFS_CTRL_RST);
      `DFS_OFF_STATUS: return {22'h0, DFS_OFF, 8'h00};
      `DFS_OFF_VEL_THR, `DFS_OFF_POS_THR: return 32'h400;
      `DFS_OFF_CAN_TMO: return 32'(`DFS_CAN_TMO_RST);
      `DFS_OFF_DECEL: return 32'(`DFS_DECEL_RST);
      default: return 32'h0;
    endcase
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++t < 20);
    rdat = dato;
    if (t >= 20) n_errors++;
    cyc <= 1'b0;
  endtask
  // enable needs a fresh 0 to 1 edge
  task automatic en(logic [31:0] c);
    wb(1'b1, `DFS_OFF_CTRL, 32'h0);
    wb(1'b1, `DFS_OFF_CTRL, c);
    repeat (4) @(posedge clk_i);
  endtask
  task automatic fault(int i);
    int t;
    logic sd;
    t = 0;
    sd = 1'b0;
    dly <= 8'(i * 7 + 1);
    flt[i] <= 1'b1;
    do begin
      @(posedge clk_i);
      sd |= dec;
    end while (pwm && ++t < 300);
    chk("decel", sd, !(i == 5 || i == 7 || i == 8));
    chk("display", disp, CODE[i]);
    wb(1'b0, `DFS_OFF_FAULT, 32'h0);
    chk("fault", rdat[FBIT[i]], 1'b1);
    flt[i] <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b0, `DFS_OFF_FAULT, 32'h0);
    chk("latched", rdat[FBIT[i]], i != 3 && i != 4);
    en(32'h17);
    chk("restart", pwm, 1'b1);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, `DFS_OFF_FAULT, 32'hFFFF);
    wb(1'b1, 8'h30, 32'hFFFF);
    for (int a = 0; a < 'h34; a += 4) begin
      wb(1'b0, 8'(a), 32'h0);
      chk("reset value", rdat, a == 'h1C ? 32'h19 : rv(8'(a)));
    end
    en(32'h17);
    chk("enable", pwm, 1'b1);
    chk("rate", rate, 16'h0FA0);
    for (int i = 0; i < 10; i++) fault(i);
    // winding fault arriving mid ramp aborts the stop
    dly <= 8'hC8;
    flt[3] <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("mid decel", dec, 1'b1);
    flt[8] <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("abort", pwm, 1'b0);
    chk("priority", disp, `DFS_CODE_F6);
    flt <= 10'h000;
    repeat (4) @(posedge clk_i);
    en(32'h17);
    for (int m = 1; m < 3; m++) begin
      wb(1'b1, `DFS_OFF_CTRL, 32'h07 | (m << 4));
      for (int k = 0; k < 12; k++) begin
        seed = xs(seed);
        verr <= (k < 2) ? 16'h0400 + 16'(k) : {5'h00, seed[10:0]};
        perr <= {5'h00, seed[21:11]};
        {fold, ovl, warm} <= seed[24:22];
        temp <= (k == 2) ? 8'd155 : 8'd128 + 8'(seed[26:25]);
        rpow <= seed[15:0];
        repeat (5) @(posedge clk_i);
        wb(1'b0, `DFS_OFF_WARN, 32'h0);
        chk("warn", rdat, {25'h0, 1'b0, ovl, verr > 16'h0400,
          m == 2 && perr > 16'h0400, warm, temp > 8'd130, fold});
        chk("no trip", pwm, 1'b1);
      end
    end
    {fold, ovl, warm, verr, perr, temp} <= {3'h0, 32'h0, 8'd25};
    wb(1'b1, `DFS_OFF_CTRL, 32'h17);
    lcw <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("block", {bcw, bccw}, 2'b11);
    wb(1'b0, `DFS_OFF_WARN, 32'h0);
    chk("limit warn", rdat, 32'h40);
    wb(1'b1, `DFS_OFF_CTRL, 32'h15);
    repeat (5) @(posedge clk_i);
    wb(1'b0, `DFS_OFF_WARN, 32'h0);
    chk("limit off", rdat, 32'h0);
    lcw <= 1'b0;
    wb(1'b1, `DFS_OFF_CTRL, 32'h1F);
    refok <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("hold", {hold, pwm}, 2'b11);
    refok <= 1'b1;
    wb(1'b1, `DFS_OFF_CTRL, 32'h0);
    ss <= 1'b1;
    repeat (6) @(posedge clk_i);
    wb(1'b1, `DFS_OFF_CTRL, 32'h17);
    repeat (4) @(posedge clk_i);
    wb(1'b0, `DFS_OFF_FAULT, 32'h0);
    chk("soft start", {rdat[2], pwm}, 2'b10);
    ss <= 1'b0;
    repeat (4) @(posedge clk_i);
    en(32'h17);
    chk("soft done", pwm, 1'b1);
    rst_i <= 1'b1;
    flt[2] <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, `DFS_OFF_FAULT, 32'h0);
    chk("boot fuse", rdat, 32'h186);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    tally_and_finish();
  end
endmodule
